// >>> hdl/cdh_consts.vh
// Behaviour
// RULE1: System-error bit sets on error message sent while enabled; W1C.
// RULE2: Parity-error bit sets on poisoned packet received; W1C.
// RULE3: Class fields read 00h, 80h and 06h; writes ignored.
// RULE4: Cache line size is 8-bit read-write, resets zero, no effect.
// RULE5: Header type reads 00h, multi-function bit zero; read-only.
// RULE6: First BAR: memory, type in 2:1, 18:4 zero, 31:19 writable.
// RULE7: Second BAR reads zero unless first type is 10b, then writable.
// RULE8: Third BAR: memory, type, prefetch, 19:4 zero, 31:20 writable.
// RULE9: Fourth BAR fixed when third is 32-bit, else writable upper.
// RULE10: Fifth BAR: memory, type, prefetch, 19:4 zero, 31:20 writable.
// RULE11: Sixth BAR fixed when fifth is 32-bit, else writable upper.
// RULE12: Read-only 8-bit revision field reports the device revision.
// RULE13: Capability pointer reads 40h, the power management structure.
// RULE14: Interrupt line is 8-bit read-write storage, resets to zero.
// RULE15: Interrupt pin reads 1h, legacy INTA in use.
// RULE16: Power capability reads ID 01h, next pointer 48h, version 011b.
// RULE17: D1, D2, power-event clock and device-init bits read zero.
// RULE18: Two-bit read-write power state: D0, D1, D2, D3hot.
// RULE19: Writing D0 from D3 gives hot reset, downstream reset untouched.
// RULE20: Skip-reset flag reads 1; when clear, leaving D3hot resets inside.
// RULE21: Read-write power-event enable bit allows power event messages.
// RULE22: Command bit 8 enables error reporting, gating system-error status.
// RULE23: Reserved and unsupported bits read zero and ignore writes.
`ifndef CDH_CONSTS_VH
`define CDH_CONSTS_VH

`define CDH_OFF_CMD_STS     8'h04
`define CDH_OFF_CLASS_REV   8'h08
`define CDH_OFF_HDR         8'h0C
`define CDH_OFF_BAR0        8'h10
`define CDH_OFF_BAR1        8'h14
`define CDH_OFF_BAR2        8'h18
`define CDH_OFF_BAR3        8'h1C
`define CDH_OFF_BAR4        8'h20
`define CDH_OFF_BAR5        8'h24
`define CDH_OFF_SUBSYS      8'h2C
`define CDH_OFF_CAP_PTR     8'h34
`define CDH_OFF_INTR        8'h3C
`define CDH_OFF_PM_CAP      8'h40
`define CDH_OFF_PM_CSR      8'h44

`define CDH_PROG_IF         8'h00
`define CDH_SUB_CLASS       8'h80
`define CDH_BASE_CLASS      8'h06
`define CDH_HDR_TYPE        8'h00
`define CDH_CAP_PTR         8'h40
`define CDH_INT_PIN         8'h01
`define CDH_PM_CAP_ID       8'h01
`define CDH_PM_NEXT         8'h48
`define CDH_PM_VER          3'h3
`define CDH_TYPE_64         2'h2
`define CDH_D0              2'h0
`define CDH_D3HOT           2'h3

`define CDH_BIT_SERR_EN     8
`define CDH_BIT_CAP_LIST    20
`define CDH_BIT_SSE         30
`define CDH_BIT_DPE         31
`define CDH_BIT_NOSOFT      3
`define CDH_BIT_PME_EN      8

`define CDH_BAR0_LO         19
`define CDH_BAR_LO          20
`define CDH_HOTRST_CYC      4'h8

`endif

// >>> hdl/cdh_pm_reset.v
`timescale 1ns/1ps
`include "cdh_consts.vh"
// Sequences the reset pulse that follows a D3hot-to-D0 write.
module cdh_pm_reset
(
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire       i_start,
  input  wire       i_internal,
  output reg        o_hot_reset,
  output reg        o_int_reset
);

  reg  [3:0]  cnt_r;

  always @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cnt_r       <= 4'h0;
      o_hot_reset <= 1'b0;
      o_int_reset <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_r       <= `CDH_HOTRST_CYC;
      o_hot_reset <= 1'b1;                      // RULE19
      o_int_reset <= i_internal;                // RULE20
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1)
      begin
        o_hot_reset <= 1'b0;
        o_int_reset <= 1'b0;
      end
    end
  end

endmodule

// >>> hdl/cdh_config_header.v
`timescale 1ns/1ps
`include "cdh_consts.vh"
// Type 0 configuration header of a port in cross-domain endpoint mode.
module cdh_config_header
#(
  parameter [7:0]  REVISION     = 8'h01,   // Arbitrary value.
  parameter [15:0] SUBSYS_VEND  = 16'h1111, // Arbitrary value.
  parameter [15:0] SUBSYS_DEV   = 16'h2222, // Arbitrary value.
  parameter [1:0]  BAR0_TYPE    = 2'h0,
  parameter [1:0]  BAR2_TYPE    = 2'h0,
  parameter        BAR2_PREF    = 1'b0,
  parameter [1:0]  BAR4_TYPE    = 2'h0,
  parameter        BAR4_PREF    = 1'b0,
  parameter        NO_SOFT_RST  = 1'b1
)
(
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_cfg_wr,
  input  wire        i_cfg_rd,
  input  wire [7:0]  i_cfg_addr,
  input  wire [3:0]  i_cfg_be,
  input  wire [31:0] i_cfg_wdata,
  output reg  [31:0] o_cfg_rdata,
  output reg         o_cfg_ack,
  input  wire        i_err_msg_sent,
  input  wire        i_poisoned_rx,
  output wire [1:0]  o_power_state,
  output wire        o_pme_enable,
  output wire        o_cache_line_size_unused,
  output wire        o_hot_reset,
  output wire        o_internal_reset,
  output wire        o_downstream_reset_out_n,
  output wire [63:0] o_bar0_base,
  output wire [63:0] o_bar2_base,
  output wire [63:0] o_bar4_base
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg         serr_en_r;
  reg         sse_r;
  reg         dpe_r;
  reg  [7:0]  cache_line_r;
  reg  [12:0] bar0_r;
  reg  [31:0] bar1_r;
  reg  [11:0] bar2_r;
  reg  [31:0] bar3_r;
  reg  [11:0] bar4_r;
  reg  [31:0] bar5_r;
  reg  [7:0]  int_line_r;
  reg  [1:0]  pstate_r;
  reg         pme_en_r;
  reg         pm_start_r;
  reg         pm_internal_r;
  reg  [31:0] rd_nxt;

  // Pairing is a build strap: a 64-bit low BAR turns its partner into the
  // upper address word, otherwise the partner stays a fixed 32-bit BAR.
  localparam BAR1_LIVE = (BAR0_TYPE == `CDH_TYPE_64);
  localparam BAR3_LIVE = (BAR2_TYPE == `CDH_TYPE_64);
  localparam BAR5_LIVE = (BAR4_TYPE == `CDH_TYPE_64);

  wire        wr_cmd;
  wire        wr_bar0;
  wire        wr_bar1;
  wire        wr_bar2;
  wire        wr_bar3;
  wire        wr_bar4;
  wire        wr_bar5;
  wire        wr_hdr;
  wire        wr_intr;
  wire        wr_pm;
  wire [31:0] bmask;
  wire [1:0]  ps_wr_val;

  // Byte-enable merge; used by the upper-word BAR1, BAR3 and BAR5 registers.
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  // Memory BAR low nibble: memory space, type, prefetch.
  function [3:0] bar_lo;
    input [1:0] typ;
    input       pref;
    begin
      bar_lo = {pref, typ, 1'b0};
    end
  endfunction

  assign bmask   = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                    {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  assign wr_cmd  = i_cfg_wr && (i_cfg_addr == `CDH_OFF_CMD_STS);
  assign wr_hdr  = i_cfg_wr && (i_cfg_addr == `CDH_OFF_HDR);
  assign wr_bar0 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR0);
  assign wr_bar1 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR1);
  assign wr_bar2 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR2);
  assign wr_bar3 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR3);
  assign wr_bar4 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR4);
  assign wr_bar5 = i_cfg_wr && (i_cfg_addr == `CDH_OFF_BAR5);
  assign wr_intr = i_cfg_wr && (i_cfg_addr == `CDH_OFF_INTR);
  assign wr_pm   = i_cfg_wr && (i_cfg_addr == `CDH_OFF_PM_CSR);
  assign ps_wr_val = i_cfg_wdata[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  // Error reporting enable, the only live bit of the command word.
  always @(posedge i_clk)
  begin
    if (!i_rst_b)
      serr_en_r <= 1'b0;
    else if (wr_cmd && i_cfg_be[1])
      serr_en_r <= i_cfg_wdata[`CDH_BIT_SERR_EN];     // RULE22
  end

  // A new event in the clearing cycle keeps the flag set, so software
  // never loses an error that lands on its own write-one-to-clear.
  always @(posedge i_clk)
  begin
    if (!i_rst_b)
      sse_r <= 1'b0;
    else if (i_err_msg_sent && serr_en_r)              // RULE22
      sse_r <= 1'b1;                                   // RULE1
    else if (wr_cmd && i_cfg_be[3] && i_cfg_wdata[`CDH_BIT_SSE])
      sse_r <= 1'b0;                                   // RULE1
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_b)
      dpe_r <= 1'b0;
    else if (i_poisoned_rx)
      dpe_r <= 1'b1;                                   // RULE2
    else if (wr_cmd && i_cfg_be[3] && i_cfg_wdata[`CDH_BIT_DPE])
      dpe_r <= 1'b0;                                   // RULE2
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable fields.  BAR types are straps, so pairing is fixed per build.

  always @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cache_line_r <= 8'h00;
      bar0_r       <= 13'h0000;
      bar1_r       <= 32'h00000000;
      bar2_r       <= 12'h000;
      bar3_r       <= 32'h00000000;
      bar4_r       <= 12'h000;
      bar5_r       <= 32'h00000000;
      int_line_r   <= 8'h00;
    end
    else
    begin
      if (wr_hdr && i_cfg_be[0])
        cache_line_r <= i_cfg_wdata[7:0];              // RULE4
      // Only the base bits are stored; the fixed low bits are rebuilt on read.
      if (wr_bar0)
      begin
        bar0_r <= (bar0_r & ~bmask[31:`CDH_BAR0_LO]) |       // RULE6
                  (i_cfg_wdata[31:`CDH_BAR0_LO] & bmask[31:`CDH_BAR0_LO]);
      end
      if (wr_bar1 && BAR0_TYPE == `CDH_TYPE_64)
        bar1_r <= merge(bar1_r, i_cfg_wdata, bmask);   // RULE7
      if (wr_bar2)
      begin
        bar2_r <= (bar2_r & ~bmask[31:`CDH_BAR_LO]) |         // RULE8
                  (i_cfg_wdata[31:`CDH_BAR_LO] & bmask[31:`CDH_BAR_LO]);
      end
      if (wr_bar3 && BAR2_TYPE == `CDH_TYPE_64)
        bar3_r <= merge(bar3_r, i_cfg_wdata, bmask);   // RULE9
      if (wr_bar4)
      begin
        bar4_r <= (bar4_r & ~bmask[31:`CDH_BAR_LO]) |         // RULE10
                  (i_cfg_wdata[31:`CDH_BAR_LO] & bmask[31:`CDH_BAR_LO]);
      end
      if (wr_bar5 && BAR4_TYPE == `CDH_TYPE_64)
        bar5_r <= merge(bar5_r, i_cfg_wdata, bmask);   // RULE11
      if (wr_intr && i_cfg_be[0])
        int_line_r <= i_cfg_wdata[7:0];                // RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power management control.

  always @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pstate_r      <= `CDH_D0;
      pm_start_r    <= 1'b0;
      pm_internal_r <= 1'b0;
    end
    else
    begin
      pm_start_r    <= 1'b0;
      pm_internal_r <= 1'b0;
      if (wr_pm && i_cfg_be[0])
      begin
        pstate_r <= ps_wr_val;                         // RULE18
        if (pstate_r == `CDH_D3HOT && ps_wr_val == `CDH_D0)
        begin
          pm_start_r    <= 1'b1;                       // RULE19
          pm_internal_r <= ~NO_SOFT_RST;               // RULE20
        end
      end
    end
  end

  // The enable is only stored; message generation lives elsewhere.
  always @(posedge i_clk)
  begin
    if (!i_rst_b)
      pme_en_r <= 1'b0;
    else if (wr_pm && i_cfg_be[1])
      pme_en_r <= i_cfg_wdata[`CDH_BIT_PME_EN];        // RULE21
  end

  cdh_pm_reset u_pm_reset
  (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_start     (pm_start_r),
    .i_internal  (pm_internal_r),
    .o_hot_reset (o_hot_reset),
    .o_int_reset (o_internal_reset)
  );

  // The downstream reset is never driven by the power-state hot reset.
  assign o_downstream_reset_out_n = 1'b1;              // RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Read path: the word is decoded combinationally and registered, so the
  // answer stands together with the acknowledge one cycle after the strobe.
  // The read data holds until the next read, which lets a slow host take
  // it late; writes never disturb it.

  always @*
  begin
    rd_nxt = 32'h00000000;
    case (i_cfg_addr)
      `CDH_OFF_CMD_STS:
        rd_nxt = {dpe_r, sse_r, 9'h000, 1'b1,
                  11'h000, serr_en_r, 8'h00};
      `CDH_OFF_CLASS_REV:
        rd_nxt = {`CDH_BASE_CLASS, `CDH_SUB_CLASS,
                  `CDH_PROG_IF, REVISION};             // RULE3 RULE12
      `CDH_OFF_HDR:
        rd_nxt = {8'h00, `CDH_HDR_TYPE, 8'h00,
                  cache_line_r};                       // RULE5
      `CDH_OFF_BAR0:
        rd_nxt = {bar0_r, 15'h0000,
                  bar_lo(BAR0_TYPE, 1'b0)};            // RULE6
      `CDH_OFF_BAR1:
        rd_nxt = BAR1_LIVE ? bar1_r : 32'h00000000;    // RULE7
      `CDH_OFF_BAR2:
        rd_nxt = {bar2_r, 16'h0000,
                  bar_lo(BAR2_TYPE, BAR2_PREF)};       // RULE8
      `CDH_OFF_BAR3:
        rd_nxt = BAR3_LIVE ? bar3_r :
                 {28'h0000000, bar_lo(2'h0, 1'b0)};    // RULE9
      `CDH_OFF_BAR4:
        rd_nxt = {bar4_r, 16'h0000,
                  bar_lo(BAR4_TYPE, BAR4_PREF)};       // RULE10
      `CDH_OFF_BAR5:
        rd_nxt = BAR5_LIVE ? bar5_r :
                 {28'h0000000, bar_lo(2'h0, 1'b0)};    // RULE11
      `CDH_OFF_SUBSYS:
        rd_nxt = {SUBSYS_DEV, SUBSYS_VEND};
      `CDH_OFF_CAP_PTR:
        rd_nxt = {24'h000000, `CDH_CAP_PTR};           // RULE13
      `CDH_OFF_INTR:
        rd_nxt = {16'h0000, `CDH_INT_PIN,
                  int_line_r};                         // RULE15
      `CDH_OFF_PM_CAP:
        rd_nxt = {5'h00, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0,
                  `CDH_PM_VER, `CDH_PM_NEXT,
                  `CDH_PM_CAP_ID};                     // RULE16 RULE17
      `CDH_OFF_PM_CSR:
        rd_nxt = {16'h0000, 7'h00, pme_en_r, 4'h0,
                  NO_SOFT_RST, 1'b0, pstate_r};        // RULE20
      default:
        rd_nxt = 32'h00000000;                         // RULE23
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_cfg_rdata <= 32'h00000000;
      o_cfg_ack   <= 1'b0;
    end
    else
    begin
      o_cfg_ack <= i_cfg_rd | i_cfg_wr;
      if (i_cfg_rd)
        o_cfg_rdata <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the rest of the port.

  assign o_power_state            = pstate_r;
  assign o_pme_enable             = pme_en_r;
  // Kept only for legacy visibility; nothing in the port consumes it.
  assign o_cache_line_size_unused = ^cache_line_r;
  // Decoded bases for the address match logic. A 32-bit BAR keeps its
  // upper word at zero, so a stale partner value can never widen a match.
  assign o_bar0_base = {BAR1_LIVE ? bar1_r : 32'h00000000,
                        bar0_r, 19'h00000};
  assign o_bar2_base = {BAR3_LIVE ? bar3_r : 32'h00000000,
                        bar2_r, 20'h00000};
  assign o_bar4_base = {BAR5_LIVE ? bar5_r : 32'h00000000,
                        bar4_r, 20'h00000};

endmodule

// >>> test/cdh_config_header_asserts.sv
`timescale 1ns/1ps
module cdh_config_header_asserts
#(
  parameter NO_SOFT_RST = 1'b1
)
(
  input wire        i_clk,
  input wire        i_rst_b,
  input wire        i_cfg_wr,
  input wire [7:0]  i_cfg_addr,
  input wire [3:0]  i_cfg_be,
  input wire [31:0] i_cfg_wdata,
  input wire [1:0]  o_power_state,
  input wire        o_pme_enable,
  input wire        o_hot_reset,
  input wire        o_internal_reset,
  input wire        o_downstream_reset_out_n,
  input wire [63:0] o_bar0_base,
  input wire [63:0] o_bar2_base
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////
  sequence s_pm_wr;
    i_cfg_wr && i_cfg_addr == 8'h44;
  endsequence
  sequence s_leave_d3;
    o_power_state == 2'h3 ##1 o_power_state == 2'h0;
  endsequence
  sequence s_hot_pulse;
    o_hot_reset [*8] ##1 !o_hot_reset;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_dsrst_never_low: assert property (o_downstream_reset_out_n)
    else $error("downstream reset asserted");
  a_hot_rst_cause: assert property (
    s_leave_d3 |-> ##[1:3] $rose(o_hot_reset))
    else $error("no hot reset after leaving D3hot");
  a_hot_rst_len: assert property (
    $rose(o_hot_reset) |-> s_hot_pulse)
    else $error("hot reset pulse length wrong");
  a_no_int_rst: assert property (NO_SOFT_RST |-> !o_internal_reset)
    else $error("internal reset while skip flag set");
  a_pstate_write: assert property (
    s_pm_wr ##0 i_cfg_be[0] |=> o_power_state == $past(i_cfg_wdata[1:0]))
    else $error("power state not written");
  a_pstate_hold: assert property (
    !(i_cfg_wr && i_cfg_addr == 8'h44) |=> $stable(o_power_state))
    else $error("power state changed without write");
  a_pme_write: assert property (
    s_pm_wr ##0 i_cfg_be[1] |=> o_pme_enable == $past(i_cfg_wdata[8]))
    else $error("power event enable not written");
  a_bar_low_zero: assert property (
    o_bar0_base[18:0] == 19'h0 && o_bar2_base[19:0] == 20'h0)
    else $error("base low bits not zero");
endmodule

bind cdh_config_header cdh_config_header_asserts
  #(.NO_SOFT_RST(NO_SOFT_RST)) i_cdh_config_header_asserts
  (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_wr(i_cfg_wr),
   .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
   .i_cfg_wdata(i_cfg_wdata), .o_power_state(o_power_state),
   .o_pme_enable(o_pme_enable), .o_hot_reset(o_hot_reset),
   .o_internal_reset(o_internal_reset),
   .o_downstream_reset_out_n(o_downstream_reset_out_n),
   .o_bar0_base(o_bar0_base), .o_bar2_base(o_bar2_base));

// >>> test/cdh_host_model.sv
`timescale 1ns/1ps
module cdh_host_model
(
  input  wire        i_clk,
  input  wire        i_ack,
  input  wire [31:0] i_rdata,
  output reg         o_wr,
  output reg         o_rd,
  output reg  [7:0]  o_addr,
  output reg  [3:0]  o_be,
  output reg  [31:0] o_wdata
);
  integer tmo;
  initial
  begin
    tmo = 0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end
  // Strobes are single-cycle pulses; afterwards the data lines carry the
  // inverse so a stale value can never pass for a held one.
  task xfer(input rd, input [7:0] a, input [3:0] be, input [31:0] d,
            output [31:0] q);
    integer n;
    begin
      @(negedge i_clk);
      o_rd = rd;
      o_wr = !rd;
      o_addr = a;
      o_be = be;
      o_wdata = d;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = ~d;
      n = 0;
      while (i_ack !== 1'b1 && n < 4)
      begin
        @(negedge i_clk);
        n = n + 1;
      end
      if (i_ack !== 1'b1)
        tmo = tmo + 1;
      q = i_rdata;
    end
  endtask
endmodule

// >>> test/test_cross_domain_type0_config_header.sv
`timescale 1ns/1ps
module test_cross_domain_type0_config_header;
  reg         clk, rst_b, err, poison;
  wire        wr, rd, ack, hot, irst, dsrst, pme;
  wire [7:0]  addr;
  wire [3:0]  be;
  wire [31:0] wdata, rdata;
  wire [1:0]  pstate;
  wire [63:0] b0, b2, b4;
  integer     bad_count, total_checks, i, n;
  reg  [31:0] q;
  reg  [71:0] tab [0:14];

  cdh_config_header #(.BAR0_TYPE(2'h2), .BAR2_TYPE(2'h2), .BAR2_PREF(1'b1))
  i_cdh_config_header (.i_clk(clk), .i_rst_b(rst_b), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .o_cfg_ack(ack), .i_err_msg_sent(err),
    .i_poisoned_rx(poison), .o_power_state(pstate), .o_pme_enable(pme),
    .o_cache_line_size_unused(), .o_hot_reset(hot),
    .o_internal_reset(irst), .o_downstream_reset_out_n(dsrst),
    .o_bar0_base(b0), .o_bar2_base(b2), .o_bar4_base(b4));
  cdh_host_model i_cdh_host_model (.i_clk(clk), .i_ack(ack),
    .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_be(be),
    .o_wdata(wdata));
  ////////////////////////////////////////////////////////////////
  task check(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      check(i_cdh_host_model.tmo, 0);
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task rw(input r, input [7:0] a, input [3:0] e, input [31:0] d);
    i_cdh_host_model.xfer(r, a, e, d, q);
  endtask
  task pulse(input e, input p);
    begin
      @(negedge clk);
      err = e;
      poison = p;
      @(negedge clk);
      err = 1'b0;
      poison = 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task scn_table(input use_ones);
    begin
      for (i = 0; i < 15; i = i + 1)
      begin
        rw(1'b1, tab[i][71:64], 4'hF, 32'h0);
        check(q, use_ones ? tab[i][31:0] : tab[i][63:32]);
      end
    end
  endtask
  task scn_write_ones;
    begin
      for (i = 0; i < 15; i = i + 1)
        rw(1'b0, tab[i][71:64], 4'hF, 32'hFFFFFFFF);
      scn_table(1'b1);
      check(b0, {32'hFFFFFFFF, 32'hFFF80000});
      check(b2, {32'hFFFFFFFF, 32'hFFF00000});
      check(b4, {32'h0, 32'hFFF00000});
      check({pstate, pme}, 3'h7);
    end
  endtask
  task scn_hot_reset;
    begin
      for (i = 1; i < 4; i = i + 1)
      begin
        rw(1'b0, 8'h44, 4'h1, i);
        check(pstate, i);
      end
      rw(1'b0, 8'h44, 4'h1, 32'h0);
      n = 0;
      while (hot !== 1'b1 && n < 6)
      begin
        @(negedge clk);
        n = n + 1;
      end
      check(n < 6, 1'b1);
      n = 0;
      while (hot === 1'b1 && n < 20)
      begin
        check({irst, dsrst}, 2'b01);
        @(negedge clk);
        n = n + 1;
      end
      check(n, 8);
      check(pstate, 2'h0);
    end
  endtask
  task scn_errors;
    begin
      rw(1'b0, 8'h04, 4'h2, 32'h100);
      pulse(1'b1, 1'b1);
      rw(1'b1, 8'h04, 4'hF, 32'h0);
      check(q, 32'hC0100100);
      rw(1'b0, 8'h04, 4'h8, 32'hC0000000);
      rw(1'b1, 8'h04, 4'hF, 32'h0);
      check(q, 32'h00100100);
      rw(1'b0, 8'h04, 4'h2, 32'h0);
      pulse(1'b1, 1'b1);
      rw(1'b1, 8'h04, 4'hF, 32'h0);
      check(q, 32'h80100000);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst_b = 1'b0;
    err = 1'b0;
    poison = 1'b0;
    tab[0]  = {8'h04, 32'h00100000, 32'h00100100};
    tab[1]  = {8'h08, 32'h06800001, 32'h06800001};
    tab[2]  = {8'h0C, 32'h00000000, 32'h000000FF};
    tab[3]  = {8'h10, 32'h00000004, 32'hFFF80004};
    tab[4]  = {8'h14, 32'h00000000, 32'hFFFFFFFF};
    tab[5]  = {8'h18, 32'h0000000C, 32'hFFF0000C};
    tab[6]  = {8'h1C, 32'h00000000, 32'hFFFFFFFF};
    tab[7]  = {8'h20, 32'h00000000, 32'hFFF00000};
    tab[8]  = {8'h24, 32'h00000000, 32'h00000000};
    tab[9]  = {8'h28, 32'h00000000, 32'h00000000};
    tab[10] = {8'h2C, 32'h22221111, 32'h22221111};
    tab[11] = {8'h34, 32'h00000040, 32'h00000040};
    tab[12] = {8'h3C, 32'h00000100, 32'h000001FF};
    tab[13] = {8'h40, 32'h00034801, 32'h00034801};
    tab[14] = {8'h44, 32'h00000008, 32'h0000010B};
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    scn_table(1'b0);
    scn_write_ones();
    scn_hot_reset();
    scn_errors();
    end_sim();
  end
endmodule
